//--- core/spfic_pkg.sv
// Constants, field layout and carrier types for the serial port control block
package spfic_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 50;
	localparam int BIT_NS = 320; // Serial bit time in master mode
	localparam int HALF_CYC = (BIT_NS * CLK_MHZ) / 2000;
	localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
	localparam logic [4:0] EDGES = 5'h10; // Two edges per bit, eight bits

	// ==========================================================
	// Register addresses (word index on the plain port)
	localparam logic [2:0] ADDR_CTRL1 = 3'h0;
	localparam logic [2:0] ADDR_CTRL2 = 3'h1;
	localparam logic [2:0] ADDR_STATUS = 3'h3;
	localparam logic [2:0] ADDR_DATA = 3'h5;

	// ==========================================================
	// Control one fields
	localparam int C1_RMASK = 7;
	localparam int C1_EN = 6;
	localparam int C1_TMASK = 5;
	localparam int C1_MASTER_SELECT = 4;
	localparam int C1_CLOCK_POLARITY = 3;
	localparam int C1_CLOCK_PHASE = 2;
	localparam int C1_SOE = 1;
	localparam int C1_LSB = 0;
	localparam logic [7:0] CTRL1_RST = 8'h04;

	// Control two fields
	localparam int C2_FDEN = 4;
	localparam int C2_BIDIR = 3;
	localparam int C2_SWIRE = 0;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] CTRL2_MASK = 8'h19;

	// Status fields
	localparam int ST_RXF = 7;
	localparam int ST_TXE = 5;
	localparam int ST_FLT = 4;

	// ==========================================================
	// Pin indices
	localparam int PIN_SCK = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_MISO = 2;
	localparam int PIN_SS = 3;
	localparam logic [3:0] SYNC_RST = 4'h8; // Select idles high

	// ==========================================================
	// Types
	typedef enum logic [1:0] {M_IDLE, M_LEAD, M_RUN, M_TRAIL} spfic_mst_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} spfic_bus_t;

	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [3:0] sy1;
		logic [3:0] sy2;
		logic [3:0] sy3;
		logic [3:0] filt;
		logic prev_sck;
		logic prev_ss;
		spfic_mst_t mst;
		logic [3:0] timer;
		logic [4:0] ecount;
		logic [7:0] sh;
		logic rxb;
		logic busy;
		logic [7:0] txbuf;
		logic [7:0] rxbuf;
		logic tx_empty;
		logic rx_full;
		logic fault;
		logic tx_arm;
		logic rx_arm;
		logic fault_arm;
		logic sck_lvl;
		logic ss_out;
		logic [7:0] rdata;
		logic [3:0] pin_out;
		logic [3:0] pin_oe_n;
		logic [3:0] claim;
		logic irq;
	} spfic_state_t;

endpackage : spfic_pkg

//--- core/spfic_core.sv
// Serial port engine: pin routing, transfers, flags, mode fault and registers
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module spfic_core
	import spfic_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// Register port
	input wire spfic_bus_t bus_i,
	output logic [7:0] rdata_o,
	// Serial pins: index PIN_SCK, PIN_MOSI, PIN_MISO, PIN_SS
	input wire logic [3:0] pin_in_i,
	output logic [3:0] pin_out_o,
	output logic [3:0] pin_oe_n_o,
	output logic [3:0] pin_claim_o,
	// Interrupt request
	output logic irq_o
);

	// ==========================================================
	// State
	spfic_state_t s;
	spfic_state_t n;

	logic en;
	logic master_select;
	logic clock_phase;
	logic lsb;
	logic swire;
	logic fden;
	logic soe;
	logic ss_in;
	logic rx_in;
	logic mfault_cond;
	logic edge_ev;
	logic done_w;
	logic [4:0] e_next;
	logic samp;

	// Shift one bit in, direction chosen by bit order
	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb_first);
		shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
	endfunction : shift_in

	// ==========================================================
	// Decoded configuration
	assign en = s.ctrl1[C1_EN];
	assign master_select = s.ctrl1[C1_MASTER_SELECT];
	assign clock_phase = s.ctrl1[C1_CLOCK_PHASE];
	assign lsb = s.ctrl1[C1_LSB];
	assign swire = s.ctrl2[C2_SWIRE];
	assign fden = s.ctrl2[C2_FDEN];
	assign soe = s.ctrl1[C1_SOE];
	assign ss_in = s.filt[PIN_SS];

	// Data input follows the role and the single-wire choice
	assign rx_in = master_select ? (swire ? s.filt[PIN_MOSI] : s.filt[PIN_MISO]) : (swire ? s.filt[PIN_MISO] : s.filt[PIN_MOSI]);

	// Select low is a fault only as a fault input
	assign mfault_cond = en && master_select && fden && !soe && !ss_in;

	// One serial clock edge, own timer or filtered pin
	assign edge_ev = en && (master_select ? (s.mst == M_RUN && s.timer == 4'h0) : (s.busy && !ss_in && s.filt[PIN_SCK] != s.prev_sck));
	assign e_next = s.ecount + 5'h01;
	// Odd edges sample in phase zero, even edges in phase one
	assign samp = clock_phase ? !e_next[0] : e_next[0];
	assign done_w = edge_ev && e_next == EDGES;

	// ==========================================================
	// Next state
	always_comb begin
		n = s;
		n.rdata = 8'h00;

		// Three-stage sampling; change counted once stages two and three agree
		n.sy1 = pin_in_i;
		n.sy2 = s.sy1;
		n.sy3 = s.sy2;
		for (int i = 0; i < 4; i++) begin
			if (s.sy2[i] == s.sy3[i]) begin
				n.filt[i] = s.sy3[i];
			end
		end
		n.prev_sck = s.filt[PIN_SCK];
		n.prev_ss = s.filt[PIN_SS];

		// Register writes
		if (bus_i.wr) begin
			case (bus_i.addr)
				ADDR_CTRL1: begin
					n.ctrl1 = bus_i.wdata;
					if (s.fault_arm) begin
						n.fault = 1'b0;
					end
					n.fault_arm = 1'b0;
				end
				ADDR_CTRL2: begin
					n.ctrl2 = bus_i.wdata & CTRL2_MASK;
				end
				ADDR_DATA: begin
					// Unarmed data writes are dropped
					if (s.tx_arm) begin
						n.txbuf = bus_i.wdata;
						n.tx_empty = 1'b0;
						n.tx_arm = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads, data stands one cycle later
		if (bus_i.rd) begin
			case (bus_i.addr)
				ADDR_CTRL1: begin
					n.rdata = s.ctrl1;
				end
				ADDR_CTRL2: begin
					n.rdata = s.ctrl2;
				end
				ADDR_STATUS: begin
					n.rdata[ST_RXF] = s.rx_full;
					n.rdata[ST_TXE] = s.tx_empty;
					n.rdata[ST_FLT] = s.fault;
					n.rx_arm = s.rx_full;
					n.tx_arm = s.tx_empty;
					n.fault_arm = s.fault;
				end
				ADDR_DATA: begin
					n.rdata = s.rxbuf;
					if (s.rx_arm) begin
						n.rx_full = 1'b0;
						n.rx_arm = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Shared shift engine
		if (edge_ev) begin
			n.ecount = e_next;
			n.sck_lvl = ~s.sck_lvl;
			if (samp) begin
				n.rxb = rx_in;
			end else if (!(clock_phase && e_next == 5'h01)) begin
				n.sh = shift_in(s.sh, s.rxb, lsb);
			end
			if (done_w) begin
				// Overrun keeps the old byte, new one is lost
				if (!s.rx_full) begin
					n.rxbuf = clock_phase ? shift_in(s.sh, rx_in, lsb) : shift_in(s.sh, s.rxb, lsb);
				end
				n.rx_full = 1'b1;
				n.ecount = 5'h00;
				n.busy = 1'b0;
			end
		end

		// Master sequencing
		if (en && master_select) begin
			case (s.mst)
				M_IDLE: begin
					n.sck_lvl = 1'b0;
					if (!s.tx_empty) begin
						n.sh = s.txbuf;
						n.tx_empty = 1'b1;
						n.ss_out = 1'b0;
						n.timer = HALF_LAST;
						n.ecount = 5'h00;
						n.mst = M_LEAD;
					end
				end
				M_LEAD: begin
					// Half a bit before the first edge for both phases
					n.timer = (s.timer == 4'h0) ? 4'h0 : s.timer - 4'h1; // Land on zero, no extra wrap
					if (s.timer == 4'h0) begin
						n.mst = M_RUN;
					end
				end
				M_RUN: begin
					n.timer = (s.timer == 4'h0) ? HALF_LAST : s.timer - 4'h1;
					if (done_w) begin
						n.timer = HALF_LAST;
						n.mst = M_TRAIL;
					end
				end
				M_TRAIL: begin
					n.timer = s.timer - 4'h1;
					if (s.timer == 4'h0) begin
						n.ss_out = 1'b1;
						n.mst = M_IDLE;
					end
				end
				default: begin
					n.mst = M_IDLE;
				end
			endcase
		end else begin
			n.mst = M_IDLE;
			n.ss_out = 1'b1;
			n.sck_lvl = 1'b0; // Slave edges must not leave a half clock for the master
		end

		// Slave framing: deselect resets the bit count
		if (en && !master_select) begin
			if (ss_in) begin
				n.ecount = 5'h00;
				n.busy = 1'b0;
			end else if (!s.busy) begin
				// First bit sits on the output as soon as selected
				if (!s.tx_empty) begin
					n.sh = s.txbuf;
					n.tx_empty = 1'b1;
				end
				n.busy = 1'b1;
			end
		end

		// Disable aborts everything and empties the buffers
		if (!en) begin
			n.mst = M_IDLE;
			n.ecount = 5'h00;
			n.busy = 1'b0;
			n.rx_full = 1'b0;
			n.tx_empty = 1'b1;
			n.tx_arm = 1'b0;
			n.rx_arm = 1'b0;
			n.sck_lvl = 1'b0;
			n.ss_out = 1'b1;
		end

		// Fault last so its set wins over a clear
		if (mfault_cond) begin
			n.fault = 1'b1;
			n.ctrl1[C1_MASTER_SELECT] = 1'b0;
			n.mst = M_IDLE;
			n.ecount = 5'h00;
			n.sck_lvl = 1'b0;
			n.ss_out = 1'b1;
		end

		// Pin routing from the next state
		n.pin_out = 4'h0;
		n.pin_oe_n = 4'hF;
		n.claim = 4'h0;
		if (n.ctrl1[C1_EN]) begin
			n.claim[PIN_SCK] = 1'b1;
			n.claim[PIN_MOSI] = n.ctrl1[C1_MASTER_SELECT] || !n.ctrl2[C2_SWIRE];
			n.claim[PIN_MISO] = !n.ctrl1[C1_MASTER_SELECT] || !n.ctrl2[C2_SWIRE];
			n.claim[PIN_SS] = !n.ctrl1[C1_MASTER_SELECT] || n.ctrl2[C2_FDEN];
			if (n.ctrl1[C1_MASTER_SELECT]) begin
				n.pin_oe_n[PIN_SCK] = 1'b0;
				n.pin_out[PIN_SCK] = n.sck_lvl ^ n.ctrl1[C1_CLOCK_POLARITY];
				n.pin_out[PIN_MOSI] = n.ctrl1[C1_LSB] ? n.sh[0] : n.sh[7];
				n.pin_oe_n[PIN_MOSI] = n.ctrl2[C2_SWIRE] && !n.ctrl2[C2_BIDIR];
				if (n.ctrl2[C2_FDEN] && n.ctrl1[C1_SOE]) begin
					n.pin_oe_n[PIN_SS] = 1'b0;
					n.pin_out[PIN_SS] = n.ss_out;
				end
			end else if (!n.fault && !n.filt[PIN_SS]) begin
				// Slave output only while selected; held off after a fault
				n.pin_out[PIN_MISO] = n.ctrl1[C1_LSB] ? n.sh[0] : n.sh[7];
				n.pin_oe_n[PIN_MISO] = n.ctrl2[C2_SWIRE] && !n.ctrl2[C2_BIDIR];
			end
		end

		// Single request from masked flags
		n.irq = ((n.rx_full || n.fault) && n.ctrl1[C1_RMASK]) || (n.tx_empty && n.ctrl1[C1_TMASK]);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.ctrl1 <= CTRL1_RST;
			s.ctrl2 <= CTRL2_RST;
			s.sy1 <= SYNC_RST;
			s.sy2 <= SYNC_RST;
			s.sy3 <= SYNC_RST;
			s.filt <= SYNC_RST;
			s.prev_ss <= 1'b1;
			s.mst <= M_IDLE;
			s.tx_empty <= 1'b1;
			s.ss_out <= 1'b1;
			s.pin_oe_n <= 4'hF;
		end else begin
			s <= n;
		end
	end

	assign rdata_o = s.rdata;
	assign pin_out_o = s.pin_out;
	assign pin_oe_n_o = s.pin_oe_n;
	assign pin_claim_o = s.claim;
	assign irq_o = s.irq;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	fault_set_a: assert property (mfault_cond |=> s.fault) else $error("fault not set");
	fault_cause_a: assert property ($rose(s.fault) |-> $past(mfault_cond)) else $error("fault without cause");
	fault_drop_a: assert property ($rose(s.fault) |-> !s.ctrl1[C1_MASTER_SELECT] && s.pin_oe_n[PIN_SCK] && s.pin_oe_n[PIN_MOSI])
		else $error("fault left drivers on");
	disable_flags_a: assert property (!en |=> !s.rx_full && s.tx_empty && s.mst == M_IDLE)
		else $error("disable did not reset");
	release_pins_a: assert property (!en |-> s.claim == 4'h0 && s.pin_oe_n == 4'hF) else $error("pins held");
	clock_role_a: assert property (en && master_select |-> !s.pin_oe_n[PIN_SCK]) else $error("clock not driven");
	idle_level_a: assert property (en && master_select && s.mst == M_IDLE |-> s.pin_out[PIN_SCK] == s.ctrl1[C1_CLOCK_POLARITY])
		else $error("idle clock level");
	irq_req_a: assert property (s.rx_full && s.ctrl1[C1_RMASK] |-> s.irq) else $error("irq missing");
	tx_ignore_a: assert property (bus_i.wr && bus_i.addr == ADDR_DATA && !s.tx_arm && s.tx_empty |=> s.tx_empty)
		else $error("unarmed write taken");
	rx_clear_a: assert property (bus_i.rd && bus_i.addr == ADDR_DATA && s.rx_arm && !done_w |=> !s.rx_full)
		else $error("receive flag stuck");
	first_bit_a: assert property ($rose(s.busy) && !clock_phase && !master_select && !swire && !s.fault |->
		!s.pin_oe_n[PIN_MISO] && s.pin_out[PIN_MISO] == (lsb ? s.sh[0] : s.sh[7]))
		else $error("first bit not presented");

	master_done_c: cover property (master_select && done_w);
	slave_done_c: cover property (!master_select && done_w);
	fault_hit_c: cover property ($rose(s.fault));
	tx_taken_c: cover property (bus_i.wr && bus_i.addr == ADDR_DATA && s.tx_arm);
	select_fall_c: cover property (s.prev_ss && !s.filt[PIN_SS]);

endmodule : spfic_core

`default_nettype wire

//--- bench/spfic_peer.sv
// Far-side serial device: phase-zero slave, or master on demand
`timescale 1ns/1ps
`default_nettype none
module spfic_peer (
	// Format
	input wire logic clock_polarity_i,
	input wire logic lsb_i,
	// Pin levels seen, peer levels and drives
	input wire logic [3:0] pin_i,
	output logic [3:0] out_o,
	output logic [3:0] drv_o
);
	// ==========
	// State
	logic [7:0] sh = 8'h00;
	logic [7:0] tx = 8'h00;
	logic [3:0] mo = 4'hF;
	logic mst = 1'b0;
	logic smp = 1'b0;

	// Slave drives its data line only while selected
	assign drv_o = mst ? 4'hB : {1'b0, ~pin_i[3], 2'b00};
	assign out_o = mst ? mo : {1'b1, lsb_i ? sh[0] : sh[7], 2'b11};

	// Preload on select, so the first bit is out before any edge
	always @(negedge pin_i[3]) if (!mst) sh = tx;

	// Sample on the leading edge, shift on the trailing one
	always @(pin_i[0]) begin
		if (!mst && pin_i[3] === 1'b0) begin
			if (pin_i[0] !== clock_polarity_i) smp = pin_i[1];
			else sh = lsb_i ? {smp, sh[7:1]} : {sh[6:0], smp};
		end
	end

	// ==========
	// Master: 160 ns link clock, still outside the frame
	task automatic xfer(input logic [7:0] d, output logic [7:0] r);
		logic [7:0] s;
		s = d;
		mo = {1'b0, 1'b1, lsb_i ? s[0] : s[7], clock_polarity_i};
		mst = 1'b1;
		#160;
		repeat (8) begin
			mo[0] = ~clock_polarity_i;
			#80;
			smp = pin_i[2];
			mo[0] = clock_polarity_i;
			s = lsb_i ? {smp, s[7:1]} : {s[6:0], smp};
			mo[1] = lsb_i ? s[0] : s[7];
			#80;
		end
		mo[3] = 1'b1;
		#160;
		r = s;
		mst = 1'b0;
	endtask : xfer
endmodule : spfic_peer
`default_nettype wire

//--- bench/test_spi_pin_fault_irq_control.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module test_spi_pin_fault_irq_control;
	import spfic_pkg::*;
	// ==========
	// Signals
	logic clock_i;
	logic resetn_i;
	spfic_bus_t bus;
	logic [7:0] rdata;
	logic [3:0] pout;
	logic [3:0] oe_n;
	logic [3:0] claim;
	logic [3:0] pp;
	logic [3:0] pd;
	logic [3:0] pins;
	logic irq;
	logic clock_polarity;
	logic lsb;
	logic pull_ss;
	int mismatches;
	int n_tests;
	int cyc;

	// Wire level: block, else peer, else pull-up
	assign pins = ((~oe_n & pout) | (oe_n & ~pd) | (oe_n & pd & pp)) & {~pull_ss, 3'h7};

	spfic_core i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
		.pin_in_i(pins), .pin_out_o(pout), .pin_oe_n_o(oe_n), .pin_claim_o(claim), .irq_o(irq));
	spfic_peer i_peer (.clock_polarity_i(clock_polarity), .lsb_i(lsb), .pin_i(pins), .out_o(pp), .drv_o(pd));

	// Clock and hang guard
	always #10 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end

	// ==========
	// Helpers
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("BAD t=%0t seen %h want %h", $time, s, e);
		end
	endtask : check

	task automatic bx(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] v);
		@(posedge clock_i);
		bus <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clock_i);
		bus <= '0;
		#1;
		v = rdata;
	endtask : bx

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] v;
		bx(1'b1, a, d, v);
	endtask : wr

	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] v;
		bx(1'b0, a, 8'h00, v);
		check(v, e);
	endtask : rc

	task automatic setup(input logic [7:0] c2, input logic [7:0] c1);
		wr(ADDR_CTRL2, c2);
		wr(ADDR_CTRL1, c1);
	endtask : setup

	// Status read arms the data write
	task automatic send(input logic [7:0] d);
		logic [7:0] v;
		bx(1'b0, ADDR_STATUS, 8'h00, v);
		wr(ADDR_DATA, d);
	endtask : send

	task automatic wait_rx;
		logic [7:0] v;
		v = 8'h00;
		repeat (300) if (!v[7]) bx(1'b0, ADDR_STATUS, 8'h00, v);
	endtask : wait_rx

	task automatic wait_pin(input int k, input logic l, output int n);
		n = 0;
		while (pout[k] === l && n < 40) begin
			@(posedge clock_i);
			#1;
			n++;
		end
	endtask : wait_pin

	task automatic ck_irq(input logic e);
		repeat (2) @(posedge clock_i);
		#1;
		check({7'h00, irq}, {7'h00, e});
	endtask : ck_irq

	// ==========
	// Scenarios
	task automatic t_start;
		rc(ADDR_CTRL1, CTRL1_RST);
		rc(ADDR_CTRL2, CTRL2_RST);
		rc(3'h7, 8'h00);
		check({4'h0, claim}, 8'h00);
		wr(ADDR_CTRL2, 8'hFF);
		rc(ADDR_CTRL2, CTRL2_MASK);
		setup(8'h01, 8'h50);
		check({claim, oe_n}, 8'h3E);
		setup(8'h09, 8'h50);
		check({4'h0, oe_n}, 8'h0C);
		setup(8'h09, 8'h40);
		check({claim, oe_n}, 8'hDF);
		setup(8'h10, 8'h52);
		wr(ADDR_DATA, 8'h3C);
		repeat (200) @(posedge clock_i);
		rc(ADDR_STATUS, 8'h20);
	endtask : t_start

	task automatic t_master;
		logic [7:0] d;
		logic [7:0] e;
		int n;
		for (int i = 0; i < 4; i++) begin
			clock_polarity = i[0];
			lsb = i[1];
			d = 8'hC3 ^ 8'(i * 17);
			e = 8'h96 ^ 8'(i);
			i_peer.tx = e;
			setup(8'h10, 8'h52 | {4'h0, clock_polarity, 2'b00, lsb});
			repeat (6) @(posedge clock_i);
			#1;
			check({7'h00, pout[0]}, {7'h00, clock_polarity});
			check({4'h0, claim}, 8'h0F);
			check({4'h0, oe_n}, 8'h04);
			send(d);
			wait_pin(3, 1'b1, n);
			check({7'h00, pout[1]}, {7'h00, lsb ? d[0] : d[7]});
			wait_pin(0, clock_polarity, n);
			check({7'h00, n > 3 && n < 13}, 8'h01);
			wait_rx();
			check(i_peer.sh, d);
			rc(ADDR_DATA, e);
			rc(ADDR_STATUS, 8'h20);
		end
	endtask : t_master

	task automatic t_irq;
		clock_polarity = 1'b0;
		lsb = 1'b0;
		i_peer.tx = 8'hE7;
		setup(8'h00, 8'h60);
		ck_irq(1'b1);
		setup(8'h10, 8'hD2);
		ck_irq(1'b0);
		send(8'h11);
		wait_rx();
		ck_irq(1'b1);
		rc(ADDR_DATA, 8'hE7);
		ck_irq(1'b0);
	endtask : t_irq

	task automatic t_fault;
		setup(8'h00, 8'h50);
		pull_ss <= 1'b1;
		repeat (10) @(posedge clock_i);
		rc(ADDR_STATUS, 8'h20);
		rc(ADDR_CTRL1, 8'h50);
		check({4'h0, claim}, 8'h07);
		pull_ss <= 1'b0;
		// Let the select line settle before fault detection is armed
		repeat (6) @(posedge clock_i);
		setup(8'h10, 8'h50);
		pull_ss <= 1'b1;
		repeat (10) @(posedge clock_i);
		pull_ss <= 1'b0;
		rc(ADDR_CTRL1, 8'h40);
		check({4'h0, oe_n & 4'h7}, 8'h07);
		wr(ADDR_CTRL1, 8'h40);
		rc(ADDR_STATUS, 8'h30);
		wr(ADDR_CTRL1, 8'h40);
		rc(ADDR_STATUS, 8'h20);
	endtask : t_fault

	task automatic t_disable;
		setup(8'h10, 8'h52);
		send(8'h5A);
		repeat (40) @(posedge clock_i);
		wr(ADDR_CTRL1, 8'h12);
		repeat (3) @(posedge clock_i);
		#1;
		check({4'h0, claim}, 8'h00);
		rc(ADDR_STATUS, 8'h20);
		repeat (200) @(posedge clock_i);
		rc(ADDR_STATUS, 8'h20);
	endtask : t_disable

	task automatic t_slave;
		logic [7:0] r;
		setup(8'h00, 8'h40);
		send(8'hB4);
		fork
			i_peer.xfer(8'h69, r);
			begin
				#150;
				check({4'h0, oe_n}, 8'h0B);
				check({7'h00, pout[2]}, 8'h01);
			end
		join
		check(r, 8'hB4);
		wait_rx();
		rc(ADDR_DATA, 8'h69);
	endtask : t_slave

	// ==========
	// Verdict
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		clock_i = 1'b0;
		resetn_i = 1'b0;
		bus = '0;
		clock_polarity = 1'b0;
		lsb = 1'b0;
		pull_ss = 1'b0;
		mismatches = 0;
		n_tests = 0;
		cyc = 0;
		repeat (12) @(posedge clock_i);
		resetn_i <= 1'b1;
		t_start();
		t_master();
		t_irq();
		t_fault();
		t_disable();
		t_slave();
		final_report();
	end
endmodule : test_spi_pin_fault_irq_control
`default_nettype wire
